//--- cpr_can_pin_routing.sv
/*
  Pin routing, open-drain option and clock select for two CAN controllers
  sharing the four port 4 pins, with a small register file.
  Assumes a synchronous 16-bit register port, synchronous pin inputs and
  a transceiver or wired-AND bus on the pins.
*/
// Overview of operation
// - Open-drain select lets both transmit pins share one transceiver.
// - Parallel mode puts both controllers on pin5 receive, pin6 transmit.
// - Parallel mode frees pin4 and pin7 for GPIO or I2C.
// - Misc register is reachable only with both access enables set.
// - Parallel mapping needs both controllers enabled, else no effect.
// - With controller A off, B stays on pin4 and pin7.
// - Clock halve bit picks CPU clock or half of it for both.
// - After reset the CAN clock is the CPU clock halved.
// - Prescaler off feeds the CPU clock straight to the controllers.
// - CAN clock comes only from prescaling the CPU clock.
// - Stuffing bounds runs to five; resync edges within ten bits.
// - An error-active node sends six dominant bits as error flag, only on pin6 and only with controller A enabled.
// - A received error flag on pin5 is echoed with an own flag.
// - Resync jump width is programmable from one to four quanta.
// - Sync only on recessive-to-dominant edges.
// - Freed pins act as GPIO or I2C, never as external address lines.
// - Controller A enable is bit 0, B bit 1, with periph enable.
// - Reset sets controller A's enable bit but not periph enable, so both stay disabled.
// - Default mapping: controller B transmits pin7, receives pin4.
module cpr_can_pin_routing
  import cpr_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_ctrl_a_tx,
  input  wire logic        i_ctrl_b_tx,
  output logic             o_ctrl_a_rx,
  output logic             o_ctrl_b_rx,
  output logic             o_ctrl_a_en,
  output logic             o_ctrl_b_en,
  output logic             o_can_clk_tick,
  input  wire logic        i_bit_tick,
  input  wire logic        i_err_req,
  input  wire logic [3:0]  i_phase_err,
  output logic             o_sync_edge,
  output logic      [2:0]  o_resync_adj,
  output logic      [2:0]  o_rjw,
  output logic             o_err_dominant,
  input  wire logic [3:0]  i_p4_in,
  output logic      [3:0]  o_p4_out,
  output logic      [3:0]  o_p4_oe,
  input  wire logic        i_i2c_scl_low,
  input  wire logic        i_i2c_sda_low,
  output logic             o_i2c_en,
  output logic             o_i2c_scl,
  output logic             o_i2c_sda
);

  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] pcfg_r, pcfg_nxt;
  logic [15:0] scfg_r, scfg_nxt;
  logic [1:0]  misc_r, misc_nxt;
  logic [3:0]  p4_data_r, p4_data_nxt;
  logic [3:0]  p4_dir_r, p4_dir_nxt;
  logic [3:0]  p4_ods_r, p4_ods_nxt;
  logic [1:0]  rjw_r, rjw_nxt;
  logic        stuff_st_r, stuff_st_nxt;
  logic        gap_st_r, gap_st_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  // Derived enables and mapping
  logic a_en;
  logic b_en;
  logic par_eff;
  logic misc_ok;
  logic b_on_own;
  logic shared_tx;
  logic i2c_on;

  cpr_mon_if mon_if ();

  // Address match, shared by the write and read decoders
  function automatic logic cpr_hit(input logic [3:0] a,
                                   input logic [3:0] idx);
    return a == idx;
  endfunction

  // ****************************************
  // Enables and mapping
  // ****************************************
  assign a_en     = pcfg_r[CPR_B_CTRL_A_EN] &
                    scfg_r[CPR_B_EXT_PERIPH];
  assign b_en     = pcfg_r[CPR_B_CTRL_B_EN] &
                    scfg_r[CPR_B_EXT_PERIPH];
  assign misc_ok  = pcfg_r[CPR_B_MISC_ACC_EN] &
                    scfg_r[CPR_B_EXT_PERIPH];
  // Needs both controllers; with A off, B keeps its own pins
  assign par_eff  = misc_r[CPR_B_PAR_MAP] & a_en & b_en;
  assign b_on_own = b_en & ~par_eff;
  assign i2c_on   = pcfg_r[CPR_B_I2C_EN] & ~b_on_own;

  // Dominant wins: in parallel mode both transmitters share pin6, plus own error flag
  assign shared_tx = (a_en ? i_ctrl_a_tx : 1'b1) &
                     (par_eff ? i_ctrl_b_tx : 1'b1) &
                     ~mon_if.err_active;

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    pcfg_nxt = pcfg_r;
    scfg_nxt = scfg_r;
    misc_nxt = misc_r;
    p4_data_nxt = p4_data_r;
    p4_dir_nxt = p4_dir_r;
    p4_ods_nxt = p4_ods_r;
    rjw_nxt = rjw_r;
    stuff_st_nxt = stuff_st_r;
    gap_st_nxt = gap_st_r;
    if (i_wr) begin
      if (cpr_hit(i_addr, CPR_IDX_PERIPH_CFG)) begin
        pcfg_nxt = i_wdata & 16'h001B;
      end
      if (cpr_hit(i_addr, CPR_IDX_SYS_CFG)) begin
        scfg_nxt = i_wdata & 16'h0004;
      end
      // Locked unless both access enables are set
      if (cpr_hit(i_addr, CPR_IDX_MISC_EXT) && misc_ok) begin
        misc_nxt = i_wdata[1:0];
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_DATA)) begin
        p4_data_nxt = i_wdata[3:0];
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_DIR)) begin
        p4_dir_nxt = i_wdata[3:0];
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_ODS)) begin
        p4_ods_nxt = i_wdata[3:0];
      end
      if (cpr_hit(i_addr, CPR_IDX_CAN_TIMING)) begin
        rjw_nxt = i_wdata[1:0];
      end
      // Write one to clear sticky status
      if (cpr_hit(i_addr, CPR_IDX_STATUS)) begin
        if (i_wdata[CPR_B_ST_STUFF]) begin
          stuff_st_nxt = 1'b0;
        end
        if (i_wdata[CPR_B_ST_GAP]) begin
          gap_st_nxt = 1'b0;
        end
      end
    end
    // Set after clear so a same-cycle event is never lost
    if (mon_if.stuff_viol) begin
      stuff_st_nxt = 1'b1;
    end
    if (mon_if.gap_viol) begin
      gap_st_nxt = 1'b1;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      if (cpr_hit(i_addr, CPR_IDX_PERIPH_CFG)) begin
        rdata_nxt = pcfg_r;
      end
      if (cpr_hit(i_addr, CPR_IDX_SYS_CFG)) begin
        rdata_nxt = scfg_r;
      end
      if (cpr_hit(i_addr, CPR_IDX_MISC_EXT) && misc_ok) begin
        rdata_nxt = {14'h0000, misc_r};
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_DATA)) begin
        rdata_nxt = {12'h000, p4_data_r};
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_DIR)) begin
        rdata_nxt = {12'h000, p4_dir_r};
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_ODS)) begin
        rdata_nxt = {12'h000, p4_ods_r};
      end
      if (cpr_hit(i_addr, CPR_IDX_P4_PINS)) begin
        rdata_nxt = {12'h000, i_p4_in};
      end
      if (cpr_hit(i_addr, CPR_IDX_CAN_TIMING)) begin
        rdata_nxt = {14'h0000, rjw_r};
      end
      if (cpr_hit(i_addr, CPR_IDX_STATUS)) begin
        rdata_nxt = {10'h000, gap_st_r, stuff_st_r,
                     mon_if.err_active, par_eff, b_en, a_en};
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pcfg_r <= CPR_RST_PERIPH_CFG;
      scfg_r <= CPR_RST_SYS_CFG;
      misc_r <= CPR_RST_MISC_EXT;
      p4_data_r <= CPR_RST_P4;
      p4_dir_r <= CPR_RST_P4;
      p4_ods_r <= CPR_RST_P4;
      rjw_r <= CPR_RST_RJW;
      stuff_st_r <= 1'b0;
      gap_st_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      pcfg_r <= pcfg_nxt;
      scfg_r <= scfg_nxt;
      misc_r <= misc_nxt;
      p4_data_r <= p4_data_nxt;
      p4_dir_r <= p4_dir_nxt;
      p4_ods_r <= p4_ods_nxt;
      rjw_r <= rjw_nxt;
      stuff_st_r <= stuff_st_nxt;
      gap_st_r <= gap_st_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Pin multiplexer
  // ****************************************
  // Routing stays combinational: a register would delay bus edges
  always_comb begin
    o_p4_out = p4_data_r;
    // Open-drain drives only the low level of a GPIO pin
    for (int i = 0; i < 4; i++) begin
      o_p4_oe[i] = p4_dir_r[i] & (~p4_ods_r[i] | ~p4_data_r[i]);
    end
    // Receive pins are inputs while the controller owns them
    if (a_en) begin
      o_p4_oe[CPR_PIN5] = 1'b0;
      o_p4_out[CPR_PIN6] = shared_tx;
      o_p4_oe[CPR_PIN6] = ~p4_ods_r[CPR_PIN6] | ~shared_tx;
    end
    if (b_on_own) begin
      o_p4_oe[CPR_PIN4] = 1'b0;
      o_p4_out[CPR_PIN7] = i_ctrl_b_tx;
      o_p4_oe[CPR_PIN7] = ~p4_ods_r[CPR_PIN7] | ~i_ctrl_b_tx;
    end else if (i2c_on) begin
      // I2C lines are always open-drain, pulled low on request
      o_p4_out[CPR_PIN4] = 1'b0;
      o_p4_oe[CPR_PIN4] = i_i2c_scl_low;
      o_p4_out[CPR_PIN7] = 1'b0;
      o_p4_oe[CPR_PIN7] = i_i2c_sda_low;
    end
    // No address-line source exists on these pins at all
  end

  // Receive routing; a disabled controller sees recessive
  assign o_ctrl_a_rx = a_en ? i_p4_in[CPR_PIN5] : 1'b1;
  assign o_ctrl_b_rx = par_eff  ? i_p4_in[CPR_PIN5] :
                       b_on_own ? i_p4_in[CPR_PIN4] : 1'b1;
  assign o_i2c_en  = i2c_on;
  assign o_i2c_scl = i_p4_in[CPR_PIN4];
  assign o_i2c_sda = i_p4_in[CPR_PIN7];
  assign o_ctrl_a_en = a_en;
  assign o_ctrl_b_en = b_en;

  // ****************************************
  // Clock select and bus monitor
  // ****************************************
  // One tick drives both controllers; halving covers fast CPU clocks
  cpr_clk_div #(
    .DIV (CPR_CLK_DIV)
  ) u_clk_div (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_halve   (misc_r[CPR_B_CLK_HALVE]),
    .o_tick    (o_can_clk_tick)
  );

  assign mon_if.bit_tick  = i_bit_tick;
  assign mon_if.rx        = i_p4_in[CPR_PIN5];
  assign mon_if.err_req   = i_err_req;
  assign mon_if.rjw_prog  = rjw_r;
  assign mon_if.phase_err = i_phase_err;

  cpr_bus_mon u_bus_mon (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .mon       (mon_if)
  );

  assign o_sync_edge    = mon_if.sync_edge;
  assign o_resync_adj   = mon_if.resync_adj;
  assign o_err_dominant = mon_if.err_active;
  assign o_rjw          = {1'b0, rjw_r} + 3'h1;
  assign o_rdata        = rdata_r;

endmodule // cpr_can_pin_routing

//--- cpr_pkg.sv
/*
  Constants shared by the CAN pin routing and clock select block.
  Assumes a 16-bit register port with word indices.
*/
package cpr_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] CPR_IDX_PERIPH_CFG = 4'h0;
  localparam logic [3:0] CPR_IDX_SYS_CFG    = 4'h1;
  localparam logic [3:0] CPR_IDX_MISC_EXT   = 4'h2;
  localparam logic [3:0] CPR_IDX_P4_DATA    = 4'h3;
  localparam logic [3:0] CPR_IDX_P4_DIR     = 4'h4;
  localparam logic [3:0] CPR_IDX_P4_ODS     = 4'h5;
  localparam logic [3:0] CPR_IDX_P4_PINS    = 4'h6;
  localparam logic [3:0] CPR_IDX_CAN_TIMING = 4'h7;
  localparam logic [3:0] CPR_IDX_STATUS     = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CPR_B_CTRL_A_EN    = 0;
  localparam int CPR_B_CTRL_B_EN    = 1;
  localparam int CPR_B_I2C_EN       = 3;
  localparam int CPR_B_MISC_ACC_EN  = 4;
  localparam int CPR_B_EXT_PERIPH   = 2;
  localparam int CPR_B_PAR_MAP      = 0;
  localparam int CPR_B_CLK_HALVE    = 1;
  localparam int CPR_B_ST_STUFF     = 4;
  localparam int CPR_B_ST_GAP       = 5;

  // Port 4 pin positions inside the 4-bit pin vectors
  localparam int CPR_PIN4 = 0;
  localparam int CPR_PIN5 = 1;
  localparam int CPR_PIN6 = 2;
  localparam int CPR_PIN7 = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CPR_RST_PERIPH_CFG = 16'h0001;
  localparam logic [15:0] CPR_RST_SYS_CFG    = 16'h0000;
  localparam logic [1:0]  CPR_RST_MISC_EXT   = 2'h2;
  localparam logic [3:0]  CPR_RST_P4         = 4'h0;
  localparam logic [1:0]  CPR_RST_RJW        = 2'h0;

  // ****************************************
  // Counts
  // ****************************************
  localparam int          CPR_CLK_DIV      = 2;
  localparam logic [2:0]  CPR_STUFF_RUN    = 3'h6;
  localparam logic [2:0]  CPR_ERR_FLAG_LEN = 3'h6;
  localparam logic [3:0]  CPR_RESYNC_GAP   = 4'hA;

  typedef enum logic [0:0] {CPR_ERR_IDLE, CPR_ERR_FLAG} cpr_err_st_t;

endpackage : cpr_pkg

//--- cpr_mon_if.sv
/*
  Interface between the routing top and its bus monitor.
  Assumes all members change only on the system clock.
*/
interface cpr_mon_if;
  logic       bit_tick;
  logic       rx;
  logic       err_req;
  logic [1:0] rjw_prog;
  logic [3:0] phase_err;
  logic       sync_edge;
  logic [2:0] resync_adj;
  logic       err_active;
  logic       stuff_viol;
  logic       gap_viol;

  modport mon (input  bit_tick, rx, err_req, rjw_prog, phase_err,
               output sync_edge, resync_adj, err_active, stuff_viol,
               gap_viol);
  modport top (output bit_tick, rx, err_req, rjw_prog, phase_err,
               input  sync_edge, resync_adj, err_active, stuff_viol,
               gap_viol);
endinterface : cpr_mon_if

//--- cpr_clk_div.sv
/*
  CAN clock tick from the CPU clock: every cycle, or every DIV cycles.
  Assumes one system clock and synchronous active-low reset.
*/
module cpr_clk_div
  import cpr_pkg::*;
#(
  parameter int DIV = CPR_CLK_DIV
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_halve,
  output logic      o_tick
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;

  // ****************************************
  // Prescaler
  // ****************************************
  // No separate source: the tick is carved out of the CPU clock
  always_comb begin
    cnt_nxt  = 4'h0;
    tick_nxt = 1'b1;
    if (i_halve) begin
      tick_nxt = (cnt_r == 4'(DIV - 1));
      cnt_nxt  = tick_nxt ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_r  <= 4'h0;
      // Held high in reset so the first gap after release is one cycle
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

endmodule // cpr_clk_div

//--- cpr_bus_mon.sv
/*
  Bus monitor: sync edges, stuff runs, resync gap and error flag.
  Assumes bit_tick marks the sample point of each bit on the clock.
*/
module cpr_bus_mon
  import cpr_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  cpr_mon_if.mon    mon
);

  cpr_err_st_t st_r, st_nxt;
  logic       last_r, last_nxt;
  logic [2:0] run_r, run_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic [2:0] flag_r, flag_nxt;
  logic [2:0] adj_r, adj_nxt;
  logic       edge_r, edge_nxt;
  logic       stuff_r, stuff_nxt;
  logic       gap_v_r, gap_v_nxt;
  logic [2:0] rjw;

  assign rjw = {1'b0, mon.rjw_prog} + 3'h1;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    last_nxt = last_r;
    run_nxt = run_r;
    gap_nxt = gap_r;
    flag_nxt = flag_r;
    adj_nxt = adj_r;
    edge_nxt = 1'b0;
    stuff_nxt = 1'b0;
    gap_v_nxt = 1'b0;
    if (mon.bit_tick) begin
      last_nxt = mon.rx;
      // Only recessive to dominant counts; the other edge is ignored
      edge_nxt = last_r & ~mon.rx;
      if (edge_nxt) begin
        gap_nxt = 4'h0;
        adj_nxt = (mon.phase_err < {1'b0, rjw}) ?
                  mon.phase_err[2:0] : rjw;
      end else if (gap_r != 4'hF) begin
        gap_nxt = gap_r + 4'h1;
      end
      gap_v_nxt = ~edge_nxt && (gap_r == CPR_RESYNC_GAP);
      run_nxt = (mon.rx == last_r && run_r != 3'h7) ? run_r + 3'h1 :
                (mon.rx == last_r) ? run_r : 3'h1;
      // Six equal bits break stuffing: also how a foreign flag shows
      stuff_nxt = (run_nxt == CPR_STUFF_RUN) &&
                  (mon.rx != last_r || run_r != run_nxt);
    end
    unique case (st_r)
      CPR_ERR_IDLE: begin
        if (mon.err_req || stuff_nxt) begin
          st_nxt   = CPR_ERR_FLAG;
          flag_nxt = 3'h0;
        end
      end
      CPR_ERR_FLAG: begin
        if (mon.bit_tick) begin
          flag_nxt = flag_r + 3'h1;
          if (flag_nxt == CPR_ERR_FLAG_LEN) begin
            st_nxt = CPR_ERR_IDLE;
          end
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_r <= CPR_ERR_IDLE;
      last_r <= 1'b1;
      run_r <= 3'h0;
      gap_r <= 4'h0;
      flag_r <= 3'h0;
      adj_r <= 3'h0;
      edge_r <= 1'b0;
      stuff_r <= 1'b0;
      gap_v_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      last_r <= last_nxt;
      run_r <= run_nxt;
      gap_r <= gap_nxt;
      flag_r <= flag_nxt;
      adj_r <= adj_nxt;
      edge_r <= edge_nxt;
      stuff_r <= stuff_nxt;
      gap_v_r <= gap_v_nxt;
    end
  end

  assign mon.sync_edge  = edge_r;
  assign mon.resync_adj = adj_r;
  assign mon.err_active = (st_r == CPR_ERR_FLAG);
  assign mon.stuff_viol = stuff_r;
  assign mon.gap_viol   = gap_v_r;

endmodule // cpr_bus_mon

//--- cpr_route_asserts.sv
/*
  Checker for the CAN pin routing top: routing, CAN tick, bus monitor.
  Assumes one clock domain with synchronous active-low reset.
*/
module cpr_route_asserts
  import cpr_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_ctrl_a_tx,
  input wire logic        i_ctrl_b_tx,
  input wire logic        o_ctrl_a_rx,
  input wire logic        o_ctrl_b_rx,
  input wire logic        o_ctrl_a_en,
  input wire logic        o_ctrl_b_en,
  input wire logic        o_can_clk_tick,
  input wire logic        i_bit_tick,
  input wire logic        o_sync_edge,
  input wire logic [2:0]  o_rjw,
  input wire logic        o_err_dominant,
  input wire logic [3:0]  i_p4_in,
  input wire logic [3:0]  o_p4_out,
  input wire logic [3:0]  o_p4_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helper logic
  // ****************************************
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       lvl6;
  logic       lvl7;
  // A released pin reads as its pull-up level
  assign lvl6 = o_p4_oe[2] ? o_p4_out[2] : 1'h1;
  assign lvl7 = o_p4_oe[3] ? o_p4_out[3] : 1'h1;
  // Bit ticks seen while the error flag is driven
  always_comb begin
    cnt_nxt = o_err_dominant ? cnt_r + {2'h0, i_bit_tick} : 3'h0;
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_flag_done;
    $fell(o_err_dominant);
  endsequence
  chk_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_a_rx_route: assert property (
    o_ctrl_a_en |-> o_ctrl_a_rx == i_p4_in[1])
    else $error("controller A receive not from pin5");
  chk_b_rx_own: assert property (
    o_ctrl_b_en && !o_ctrl_a_en |-> o_ctrl_b_rx == i_p4_in[0])
    else $error("controller B receive not from pin4");
  chk_b_tx_own: assert property (
    o_ctrl_b_en && !o_ctrl_a_en |-> lvl7 == i_ctrl_b_tx)
    else $error("controller B transmit not on pin7");
  chk_pin6_level: assert property (
    o_ctrl_a_en && !o_ctrl_b_en |-> lvl6 == (i_ctrl_a_tx & !o_err_dominant))
    else $error("pin6 level wrong");
  chk_tick_gap: assert property (
    !o_can_clk_tick |=> o_can_clk_tick)
    else $error("CAN tick gap longer than two cycles");
  chk_sync_cause: assert property (
    o_sync_edge |-> $past(i_bit_tick) && !$past(i_p4_in[1]))
    else $error("sync edge without falling bus at a tick");
  chk_rjw_range: assert property (
    o_rjw != 3'h0 && o_rjw <= 3'h4)
    else $error("jump width outside one to four");
  chk_flag_len: assert property (
    s_flag_done |-> cnt_r == 3'h6)
    else $error("error flag not six bits long");
  chk_flag_bound: assert property (
    o_err_dominant |-> cnt_r <= 3'h6)
    else $error("error flag longer than six bits");
endmodule // cpr_route_asserts

bind cpr_can_pin_routing cpr_route_asserts cpr_route_asserts_inst (
  .i_clk_sys, .i_rst_n, .i_rd, .o_rdata, .i_ctrl_a_tx, .i_ctrl_b_tx,
  .o_ctrl_a_rx, .o_ctrl_b_rx, .o_ctrl_a_en, .o_ctrl_b_en, .o_can_clk_tick,
  .i_bit_tick, .o_sync_edge, .o_rjw, .o_err_dominant, .i_p4_in, .o_p4_out,
  .o_p4_oe);

//--- cpr_xcvr_model.sv
/*
  Far side: one transceiver on a wired-AND bus plus the port 4 pulls.
  Assumes pins idle at a pull-up level when nothing drives them.
*/
module cpr_xcvr_model (
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe,
  input  wire logic       i_far_tx,
  output logic      [3:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lvl;
  logic       bus;
  // Released pins float up, so open-drain senders share the line
  assign lvl = (i_oe & i_out) | ~i_oe;
  // Both transmit pins and the far node pull one bus
  assign bus = lvl[2] & lvl[3] & i_far_tx;
  // Receive pins see the bus unless pin4 is driven as GPIO
  assign o_pins = {lvl[3], lvl[2], bus, i_oe[0] ? i_out[0] : bus};
endmodule // cpr_xcvr_model

//--- testbench.sv
/*
  Self-checking bench for the CAN pin routing and clock select top.
  Assumes the transceiver model on the pins and a 50 ns clock.
*/
module testbench
  import cpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, wr, rd, a_tx, b_tx, far, tick, err, rd_d;
  logic [3:0]  addr, phe;
  logic [15:0] wd;
  logic [1:0]  rjw;
  logic [15:0] expq[$];
  wire  [15:0] rdata;
  wire  [3:0]  p4_in, p4_out, p4_oe;
  wire  [2:0]  adj, rjw_o;
  wire         a_rx, b_rx, a_en, b_en, ctick, sync, errd;
  int          errors, num_checks, syncs, c, k, flagb;

  cpr_can_pin_routing cpr_can_pin_routing_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ctrl_a_tx(a_tx),
    .i_ctrl_b_tx(b_tx), .o_ctrl_a_rx(a_rx), .o_ctrl_b_rx(b_rx),
    .o_ctrl_a_en(a_en), .o_ctrl_b_en(b_en), .o_can_clk_tick(ctick),
    .i_bit_tick(tick), .i_err_req(err), .i_phase_err(phe),
    .o_sync_edge(sync), .o_resync_adj(adj), .o_rjw(rjw_o),
    .o_err_dominant(errd), .i_p4_in(p4_in), .o_p4_out(p4_out),
    .o_p4_oe(p4_oe), .i_i2c_scl_low(1'h0), .i_i2c_sda_low(1'h0),
    .o_i2c_en(), .o_i2c_scl(), .o_i2c_sda());
  cpr_xcvr_model cpr_xcvr_model_inst (
    .i_out(p4_out), .i_oe(p4_oe), .i_far_tx(far), .o_pins(p4_in));

  // ****************************************
  // Clock, checks and closing
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d)
      chk(rdata, expq.pop_front());
    if (sync === 1'h1)
      syncs++;
    // Bit ticks that fall inside the error flag
    if (errd === 1'h1 && tick === 1'h1)
      flagb++;
  end
  // Hang guard: a run this long means a stuck sequence
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end

  // ****************************************
  // Bus and bit tasks
  // ****************************************
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'h1;
    @(posedge clk);
    wr   <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    expq.push_back(e);
    @(posedge clk);
    rd   <= 1'h0;
  endtask
  // One bus bit with its sample tick; far side drives the level v
  task automatic sbit(input logic v);
    @(posedge clk);
    far  <= v;
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic count_ticks(input int e);
    c = 0;
    // Skip the cycle in which a new halve setting lands
    @(negedge clk);
    repeat (20) begin
      @(negedge clk);
      c += int'(ctick === 1'h1);
    end
    chk(16'(c), 16'(e));
  endtask
  // Mode 0 own pins, 1 parallel, 2 controller A off
  task automatic route_loop(input int m);
    logic e;
    repeat (8) begin
      @(posedge clk);
      a_tx <= 1'($urandom);
      b_tx <= 1'($urandom);
      far  <= 1'($urandom);
      @(negedge clk);
      e = (m == 2 ? 1'h1 : a_tx) & b_tx & far;
      if (m != 2)
        chk(16'(a_rx), 16'(e));
      chk(16'(b_rx), 16'(e));
      chk(16'(p4_oe[3]), 16'(m == 1 ? 1'h0 : !b_tx));
      chk(16'(p4_oe[0]), 16'(m == 1));
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, wr, rd, a_tx, b_tx, far, tick, err} = 8'h1C;
    {addr, phe, wd} = 24'h0;
    void'($urandom(37));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(CPR_IDX_PERIPH_CFG, 16'h0001);
    rd_reg(CPR_IDX_MISC_EXT, 16'h0000);
    wr_reg(CPR_IDX_MISC_EXT, 16'h0001);
    rd_reg(4'hF, 16'h0000);
    @(negedge clk);
    chk(16'(a_en), 16'h0000);
    wr_reg(CPR_IDX_SYS_CFG, 16'h0004);
    @(negedge clk);
    chk(16'({b_en, a_en}), 16'h0001);
    wr_reg(CPR_IDX_PERIPH_CFG, 16'h0013);
    rd_reg(CPR_IDX_MISC_EXT, 16'h0002);
    count_ticks(10);
    wr_reg(CPR_IDX_P4_ODS, 16'h000C);
    wr_reg(CPR_IDX_P4_DIR, 16'h0001);
    wr_reg(CPR_IDX_P4_DATA, 16'h0000);
    route_loop(0);
    wr_reg(CPR_IDX_MISC_EXT, 16'h0001);
    count_ticks(20);
    route_loop(1);
    wr_reg(CPR_IDX_PERIPH_CFG, 16'h0012);
    route_loop(2);
    {a_tx, b_tx} <= 2'h3;
    rjw = 2'($urandom);
    phe <= 4'($urandom);
    wr_reg(CPR_IDX_CAN_TIMING, {14'h0, rjw});
    rd_reg(CPR_IDX_CAN_TIMING, {14'h0, rjw});
    syncs = 0;
    for (k = 0; k < 4; k++)
      sbit(!k[0]);
    chk(16'(syncs), 16'h0002);
    chk(16'(rjw_o), 16'(rjw) + 16'h0001);
    chk(16'(adj), (phe <= rjw) ? 16'(phe) : 16'(rjw) + 16'h0001);
    err <= 1'h1;
    sbit(1'h1);
    err <= 1'h0;
    for (k = 0; k < 10; k++)
      sbit(k[0]);
    chk(16'(flagb), 16'h0006);
    // Six equal bits look like a foreign flag and must be echoed
    for (k = 0; k < 12; k++)
      sbit(k > 5 ? k[0] : 1'h0);
    chk(16'(flagb), 16'h000C);
    rd_reg(CPR_IDX_STATUS, 16'h0012);
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule // testbench
